// >>> rtl/meter_display_loop_control.sv
// Behaviour
// - In automatic mode illumination goes off 15 s after last key, else stays on.
// - Four selectable loops: user, technician, setup, test.
// - User loop set by display selection code; technician loop fixed.
// - Technician loop shows all readings except logged and differential ones.
// - After delivery transport state makes user, technician and setup loops reachable.
// - Country setting may block setup loop even in transport state.
// - First flow at or above 1 % of nominal permanently blocks setup loop; here a reset clears the block.
// - Blocked setup loop stays unreachable until installation seal is broken.
// - Test loop reachable only while verification seal is broken.
// - Holding primary key 5 s enters loop selection view.
// - In selection view arrow keys step between available loops.
// - Index number shown in technician, setup and test loops, not user loop.
// - Confirmation indicator lights after a changed setting is stored.
// - Info symbol flashes while info code active; heartbeat always flashes.
// - Sensor fault dashes affected readings and halts dependent registers.
// - Temperature sensor fault stops dependent energy and raises readable info code.
// - Inlet or outlet fault dashes difference and power, freezes primary energies.
// - Slow-pulse flow display forced to zero after 60 minutes without pulses.
`timescale 1ns/1ps
`include "meter_display_params.svh"

module meter_display_loop_control #(
  parameter int TICK_CYCLES     = `TICK_CYCLES,
  parameter int BACKLIGHT_TICKS = `BACKLIGHT_TICKS,
  parameter int HOLD_TICKS      = `HOLD_TICKS,
  parameter int FLOW_IDLE_TICKS = `FLOW_IDLE_TICKS,
  parameter int BLINK_TICKS     = `BLINK_TICKS
) (
  input  wire logic                     clk_i,
  input  wire logic                     resetn_i,
  input  wire logic                     key_primary_i,
  input  wire logic                     key_up_i,
  input  wire logic                     key_down_i,
  input  wire logic                     install_seal_broken_i,
  input  wire logic                     verify_seal_broken_i,
  input  wire logic                     flow_pulse_i,
  input  wire logic                     backlight_auto_i,
  input  wire logic                     country_setup_block_i,
  input  wire logic                     transport_exit_i,
  input  wire logic                     flow_ge_min_i,
  input  wire logic                     slow_pulse_mode_i,
  input  wire logic                     setting_stored_i,
  input  wire logic                     info_code_active_i,
  input  wire logic [`NUM_SENSORS-1:0]  sensor_fault_i,
  output logic                          backlight_o,
  output logic [1:0]                    loop_o,
  output logic                          select_view_o,
  output logic [1:0]                    select_cand_o,
  output logic                          index_show_o,
  output logic [`INDEX_W-1:0]           view_index_o,
  output logic                          setup_avail_o,
  output logic                          ok_indicator_o,
  output logic                          info_symbol_o,
  output logic                          heartbeat_o,
  output logic [`NUM_SENSORS-1:0]       info_fault_code_o,
  output logic [`NUM_DASH-1:0]          dash_o,
  output logic [`NUM_REGS-1:0]          freeze_o,
  output logic                          flow_zero_o
);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  //////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and blink base
  logic [16:0] div_q;
  logic        tick;
  logic [15:0] blink_cnt_q;
  logic        blink_q;
  logic        blink_flip;

  assign tick       = (div_q == 17'(TICK_CYCLES - 1));
  assign blink_flip = tick && (blink_cnt_q == 16'(BLINK_TICKS - 1));

  // One slow enable drives every timer, so no second clock is needed
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q       <= '0;
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
    end else begin
      div_q <= tick ? '0 : div_q + 17'h00001;
      if (tick) begin
        blink_cnt_q <= blink_flip ? '0 : blink_cnt_q + 16'h0001;
      end
      if (blink_flip) begin
        blink_q <= ~blink_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree
  logic [`NUM_PINS-1:0] pin_raw;
  logic [`NUM_PINS-1:0] pin_lvl;
  logic [`NUM_KEYS-1:0] key_db;
  logic [`NUM_KEYS-1:0] key_prev_q;
  logic [`NUM_KEYS-1:0] key_press;

  assign pin_raw = {flow_pulse_i, verify_seal_broken_i, install_seal_broken_i,
                    key_down_i, key_up_i, key_primary_i};

  genvar gp;
  generate
    for (gp = 0; gp < `NUM_PINS; gp++) begin : g_pin
      logic s1_q, s2_q, s3_q, lvl_q;
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          s1_q <= pin_raw[gp];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign pin_lvl[gp] = lvl_q;
    end
  endgenerate

  // Key debounce: level must stand for the debounce time before it is taken
  genvar gk;
  generate
    for (gk = 0; gk < `NUM_KEYS; gk++) begin : g_key
      logic [4:0] cnt_q;
      logic       db_q;
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cnt_q <= '0;
          db_q  <= 1'b0;
        end else if (pin_lvl[gk] == db_q) begin
          cnt_q <= '0;
        end else if (tick) begin
          if (cnt_q == 5'(`DEBOUNCE_TICKS - 1)) begin
            db_q  <= pin_lvl[gk];
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
      end
      assign key_db[gk] = db_q;
    end
  endgenerate

  assign key_press = key_db & ~key_prev_q;

  //////////////////////////////////////////////////////////////////////////////
  // Access gating
  logic transport_q;
  logic flow_block_q;
  logic setup_ok;
  logic test_ok;
  logic [3:0] avail;

  assign setup_ok = (transport_q && !country_setup_block_i && !flow_block_q)
                  || pin_lvl[`PIN_SEAL_INSTALL];
  assign test_ok  = pin_lvl[`PIN_SEAL_VERIFY];
  assign avail    = {test_ok, setup_ok, 1'b1, 1'b1};

  // Flow block clears only at reset: until then only the broken seal overrides it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      transport_q  <= 1'b1;
      flow_block_q <= 1'b0;
    end else begin
      if (transport_exit_i) begin
        transport_q <= 1'b0;
      end
      if (flow_ge_min_i) begin
        flow_block_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Loop navigation
  function automatic meter_display_pkg::loop_t step_loop(input meter_display_pkg::loop_t cur,
                                                         input logic up, input logic [3:0] av);
    logic [1:0] c;
    logic       found;
    step_loop = cur;
    found     = 1'b0;
    for (int i = 1; i < 4; i++) begin
      c = up ? 2'(cur + 2'(i)) : 2'(cur - 2'(i));
      if (!found && av[c]) begin
        step_loop = meter_display_pkg::loop_t'(c);
        found     = 1'b1;
      end
    end
  endfunction : step_loop

  meter_display_pkg::nav_state_t state_q, state_d;
  meter_display_pkg::loop_t      loop_q, loop_d, cand_q, cand_d;
  logic [`INDEX_W-1:0]           index_q, index_d;
  logic [15:0]                   hold_cnt_q;
  logic                          hold_done;

  assign hold_done = tick && key_db[`PIN_KEY_PRIMARY] && (hold_cnt_q == 16'(HOLD_TICKS - 1));

  // Selection and view stepping; user loop is the fallback when access is lost
  always_comb begin
    state_d = state_q;
    loop_d  = loop_q;
    cand_d  = cand_q;
    index_d = index_q;
    unique case (state_q)
      meter_display_pkg::ST_VIEW: begin
        if (hold_done) begin
          state_d = meter_display_pkg::ST_SELECT;
          cand_d  = loop_q;
        end else if (!avail[loop_q]) begin
          loop_d  = meter_display_pkg::LOOP_USER;
          index_d = `INDEX_RESET;
        end else if (key_press[`PIN_KEY_UP]) begin
          index_d = index_q + `INDEX_W'(1);
        end else if (key_press[`PIN_KEY_DOWN]) begin
          index_d = index_q - `INDEX_W'(1);
        end
      end
      meter_display_pkg::ST_SELECT: begin
        if (!avail[cand_q]) begin
          cand_d = meter_display_pkg::LOOP_USER;
        end else if (key_press[`PIN_KEY_PRIMARY]) begin
          state_d = meter_display_pkg::ST_VIEW;
          loop_d  = cand_q;
          index_d = `INDEX_RESET;
        end else if (key_press[`PIN_KEY_UP]) begin
          cand_d = step_loop(cand_q, 1'b1, avail);
        end else if (key_press[`PIN_KEY_DOWN]) begin
          cand_d = step_loop(cand_q, 1'b0, avail);
        end
      end
    endcase
    // Access lost in either state drops the shown loop, so selection cannot keep it
    if (!avail[loop_d]) begin
      loop_d  = meter_display_pkg::LOOP_USER;
      index_d = `INDEX_RESET;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q    <= meter_display_pkg::ST_VIEW;
      loop_q     <= meter_display_pkg::LOOP_USER;
      cand_q     <= meter_display_pkg::LOOP_USER;
      index_q    <= `INDEX_RESET;
      hold_cnt_q <= '0;
      key_prev_q <= '0;
    end else begin
      state_q    <= state_d;
      loop_q     <= loop_d;
      cand_q     <= cand_d;
      index_q    <= index_d;
      key_prev_q <= key_db;
      // Hold count clears outside the view state, so a long hold fires once
      if (!key_db[`PIN_KEY_PRIMARY] || state_q != meter_display_pkg::ST_VIEW) begin
        hold_cnt_q <= '0;
      end else if (tick && !hold_done) begin
        hold_cnt_q <= hold_cnt_q + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Illumination, indicators and flow idle timer
  logic [15:0] light_cnt_q;
  logic [21:0] idle_cnt_q;
  logic        light_on;
  logic        pulse_prev_q;
  logic        pulse_edge;

  assign light_on   = !backlight_auto_i || (light_cnt_q < 16'(BACKLIGHT_TICKS));
  assign pulse_edge = pin_lvl[`PIN_FLOW_PULSE] && !pulse_prev_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      light_cnt_q  <= '0;
      idle_cnt_q   <= '0;
      pulse_prev_q <= 1'b0;
    end else begin
      pulse_prev_q <= pin_lvl[`PIN_FLOW_PULSE];
      if (|key_press) begin
        light_cnt_q <= '0;
      end else if (tick && light_cnt_q < 16'(BACKLIGHT_TICKS)) begin
        light_cnt_q <= light_cnt_q + 16'h0001;
      end
      if (pulse_edge || !slow_pulse_mode_i) begin
        idle_cnt_q <= '0;
      end else if (tick && idle_cnt_q < 22'(FLOW_IDLE_TICKS)) begin
        idle_cnt_q <= idle_cnt_q + 22'h000001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault mapping: each register stops if any sensor it depends on is faulty
  localparam logic [4*`NUM_REGS-1:0] DEP = `DEP_TABLE;
  logic [`NUM_DASH-1:0] dash_d;
  logic [`NUM_REGS-1:0] freeze_d;
  logic [`NUM_REGS-1:0] freeze_q;

  assign dash_d = {sensor_fault_i[`SENSOR_INLET] | sensor_fault_i[`SENSOR_OUTLET],
                   sensor_fault_i[`SENSOR_AUX_B], sensor_fault_i[`SENSOR_AUX_A],
                   sensor_fault_i[`SENSOR_INLET] | sensor_fault_i[`SENSOR_OUTLET],
                   sensor_fault_i[`SENSOR_OUTLET], sensor_fault_i[`SENSOR_INLET]};

  genvar gr;
  generate
    for (gr = 0; gr < `NUM_REGS; gr++) begin : g_reg
      assign freeze_d[gr] = |(DEP[4*gr +: 4] & sensor_fault_i);
    end
  endgenerate

  // All outputs leave from flip-flops; ok stays lit until the next key press
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      backlight_o       <= 1'b1;
      ok_indicator_o    <= 1'b0;
      info_symbol_o     <= 1'b0;
      heartbeat_o       <= 1'b0;
      info_fault_code_o <= '0;
      dash_o            <= '0;
      freeze_q          <= '0;
      flow_zero_o       <= 1'b0;
      index_show_o      <= 1'b0;
      setup_avail_o     <= 1'b0;
    end else begin
      backlight_o       <= light_on;
      if (setting_stored_i) begin
        ok_indicator_o <= 1'b1;
      end else if (|key_press) begin
        ok_indicator_o <= 1'b0;
      end
      info_symbol_o     <= (info_code_active_i || |sensor_fault_i) && blink_q;
      heartbeat_o       <= blink_q;
      info_fault_code_o <= sensor_fault_i;
      dash_o            <= dash_d;
      freeze_q          <= freeze_d;
      flow_zero_o       <= slow_pulse_mode_i && (idle_cnt_q >= 22'(FLOW_IDLE_TICKS));
      index_show_o      <= (loop_d != meter_display_pkg::LOOP_USER);
      setup_avail_o     <= setup_ok;
    end
  end

  assign freeze_o      = freeze_q;
  assign loop_o        = loop_q;
  assign select_cand_o = cand_q;
  assign select_view_o = state_q[1];
  assign view_index_o  = index_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_backlight_fixed: assert property (!backlight_auto_i |=> backlight_o)
    else $error("backlight off in permanent mode");
  chk_flow_block: assert property (flow_ge_min_i && !install_seal_broken_i && !pin_lvl[`PIN_SEAL_INSTALL]
    |=> ##1 !setup_avail_o)
    else $error("setup still open after flow");
  chk_test_gate: assert property (loop_o == meter_display_pkg::LOOP_TEST |-> $past(test_ok))
    else $error("test loop without seal");
  chk_select_entry: assert property ($rose(select_view_o) |-> $past(hold_done))
    else $error("selection view entered without hold");
  chk_index_user: assert property (index_show_o == (loop_o != meter_display_pkg::LOOP_USER))
    else $error("index shown in wrong loop");
  chk_ok_store: assert property (setting_stored_i |=> ok_indicator_o)
    else $error("ok not lit after store");
  chk_heart_beat: assert property (blink_flip |=> ##1 heartbeat_o != $past(heartbeat_o))
    else $error("heartbeat not toggling");
  chk_dash_inlet: assert property (sensor_fault_i[`SENSOR_INLET]
    |=> dash_o[`SENSOR_INLET] && dash_o[`DASH_DIFF] && dash_o[`DASH_POWER])
    else $error("inlet fault not dashed");
  chk_freeze_heat: assert property (sensor_fault_i[`SENSOR_OUTLET]
    |=> freeze_o[`REG_HEAT] && freeze_o[`REG_COOL] && info_fault_code_o[`SENSOR_OUTLET])
    else $error("heat energy not frozen");
  chk_flow_zero: assert property (!slow_pulse_mode_i |=> !flow_zero_o)
    else $error("flow zeroed in fast mode");

endmodule : meter_display_loop_control

// >>> rtl/meter_display_params.svh
`ifndef METER_DISPLAY_PARAMS_SVH
`define METER_DISPLAY_PARAMS_SVH

// Clock and time base
`define CLK_PERIOD_NS    10
`define TICK_TIME_NS     1000000
`define TICK_CYCLES      (`TICK_TIME_NS / `CLK_PERIOD_NS)

// Times in their own units
`define BACKLIGHT_TIME_S 15
`define HOLD_TIME_S      5
`define FLOW_IDLE_MIN    60
`define DEBOUNCE_TIME_MS 20
`define BLINK_TIME_MS    500
`define MS_PER_S         1000
`define S_PER_MIN        60

// Times as counts of millisecond ticks
`define BACKLIGHT_TICKS  (`BACKLIGHT_TIME_S * `MS_PER_S)
`define HOLD_TICKS       (`HOLD_TIME_S * `MS_PER_S)
`define FLOW_IDLE_TICKS  (`FLOW_IDLE_MIN * `S_PER_MIN * `MS_PER_S)
`define DEBOUNCE_TICKS   (`DEBOUNCE_TIME_MS)
`define BLINK_TICKS      (`BLINK_TIME_MS)

// Pin input positions in the synchroniser bank
`define PIN_KEY_PRIMARY  0
`define PIN_KEY_UP       1
`define PIN_KEY_DOWN     2
`define PIN_SEAL_INSTALL 3
`define PIN_SEAL_VERIFY  4
`define PIN_FLOW_PULSE   5
`define NUM_PINS         6
`define NUM_KEYS         3

// Sensor fault bits: inlet, outlet, aux a, aux b
`define SENSOR_INLET     0
`define SENSOR_OUTLET    1
`define SENSOR_AUX_A     2
`define SENSOR_AUX_B     3
`define NUM_SENSORS      4

// Dashed readings: inlet, outlet, difference, aux a, aux b, primary power
`define DASH_DIFF        2
`define DASH_POWER       5
`define NUM_DASH         6

// Energy and other registers that can stop counting; index 0 is heat total,
// index 2 cooling total. Four dependency bits per register, inlet in bit 0.
`define REG_HEAT         0
`define REG_COOL         2
`define NUM_REGS         18
`define DEP_TABLE        72'h33cfcf344215c65333

`define INDEX_W          8
`define INDEX_RESET      8'h00

`endif

// >>> rtl/meter_display_pkg.sv
package meter_display_pkg;

  typedef enum logic [1:0] {
    LOOP_USER  = 2'h0,
    LOOP_TECH  = 2'h1,
    LOOP_SETUP = 2'h2,
    LOOP_TEST  = 2'h3
  } loop_t;

  typedef enum logic [1:0] {
    ST_VIEW   = 2'b01,
    ST_SELECT = 2'b10
  } nav_state_t;

endpackage : meter_display_pkg

// >>> verif/key_operator.sv
`timescale 1ns/1ps

// Front panel operator: presses one key at a time, released keys read low
module key_operator (
  input  wire logic clk_i,
  output logic      key_primary_o,
  output logic      key_up_o,
  output logic      key_down_o
);

  // All keys released from time zero
  initial begin
    key_primary_o = 1'b0;
    key_up_o      = 1'b0;
    key_down_o    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Press for hold cycles, then rest so the release clears the debouncer
  task automatic press(input int key, input int hold, input int rest);
    @(negedge clk_i);
    case (key)
      0:       key_primary_o = 1'b1;
      1:       key_up_o      = 1'b1;
      default: key_down_o    = 1'b1;
    endcase
    repeat (hold) @(negedge clk_i);
    key_primary_o = 1'b0;
    key_up_o      = 1'b0;
    key_down_o    = 1'b0;
    repeat (rest) @(negedge clk_i);
  endtask : press

endmodule : key_operator

// >>> verif/meter_display_loop_control_tb.sv
`timescale 1ns/1ps
`include "meter_display_params.svh"

module meter_display_loop_control_tb;

  // Debounced level lasts about as long as the press: SHORT stays under the hold count, LONG passes it
  localparam int SHORT = 225;
  localparam int LONG  = 500;
  localparam int REST  = 260;
  localparam logic [3:0] DEP [18] = '{4'h3, 4'h3, 4'h3, 4'h5, 4'h6, 4'hc, 4'h5, 4'h1, 4'h2,
                                      4'h4, 4'h4, 4'h3, 4'hf, 4'hc, 4'hf, 4'hc, 4'h3, 4'h3};

  typedef struct { logic [3:0] fault; logic [5:0] dash; } row_t;
  row_t rows [8] = '{'{4'h0, 6'h00}, '{4'h1, 6'h25}, '{4'h2, 6'h26}, '{4'h4, 6'h08},
                     '{4'h8, 6'h10}, '{4'h3, 6'h27}, '{4'hc, 6'h18}, '{4'hf, 6'h3f}};

  logic clk_i = 1'b0, resetn_i = 1'b0;
  logic key_primary, key_up, key_down;
  logic install_seal_broken_i = 1'b0, verify_seal_broken_i = 1'b0, flow_pulse_i = 1'b0;
  logic backlight_auto_i = 1'b1, country_setup_block_i = 1'b0, transport_exit_i = 1'b0;
  logic flow_ge_min_i = 1'b0, slow_pulse_mode_i = 1'b0, setting_stored_i = 1'b0;
  logic info_code_active_i = 1'b0;
  logic [`NUM_SENSORS-1:0] sensor_fault_i = '0;
  logic backlight_o, select_view_o, index_show_o, setup_avail_o, ok_indicator_o;
  logic info_symbol_o, heartbeat_o, flow_zero_o;
  logic [1:0] loop_o, select_cand_o;
  logic [`INDEX_W-1:0] view_index_o;
  logic [`NUM_SENSORS-1:0] info_fault_code_o;
  logic [`NUM_DASH-1:0] dash_o;
  logic [`NUM_REGS-1:0] freeze_o;
  int fails = 0, comparisons = 0, n, tb_n, ti_n;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  key_operator key_operator_inst (.clk_i(clk_i), .key_primary_o(key_primary), .key_up_o(key_up),
                                  .key_down_o(key_down));

  // Counts shortened so the run stays small; hold stays above the debounce time
  meter_display_loop_control #(.TICK_CYCLES(10), .BACKLIGHT_TICKS(15), .HOLD_TICKS(40),
    .FLOW_IDLE_TICKS(20), .BLINK_TICKS(4)) meter_display_loop_control_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .key_primary_i(key_primary), .key_up_i(key_up),
    .key_down_i(key_down), .install_seal_broken_i(install_seal_broken_i),
    .verify_seal_broken_i(verify_seal_broken_i), .flow_pulse_i(flow_pulse_i),
    .backlight_auto_i(backlight_auto_i), .country_setup_block_i(country_setup_block_i),
    .transport_exit_i(transport_exit_i), .flow_ge_min_i(flow_ge_min_i),
    .slow_pulse_mode_i(slow_pulse_mode_i), .setting_stored_i(setting_stored_i),
    .info_code_active_i(info_code_active_i), .sensor_fault_i(sensor_fault_i),
    .backlight_o(backlight_o), .loop_o(loop_o), .select_view_o(select_view_o),
    .select_cand_o(select_cand_o), .index_show_o(index_show_o), .view_index_o(view_index_o),
    .setup_avail_o(setup_avail_o), .ok_indicator_o(ok_indicator_o), .info_symbol_o(info_symbol_o),
    .heartbeat_o(heartbeat_o), .info_fault_code_o(info_fault_code_o), .dash_o(dash_o),
    .freeze_o(freeze_o), .flow_zero_o(flow_zero_o));

  ////////////////////////////////////////////////////////////////////////
  // Any dependency sensor at fault stops that register
  function automatic logic [`NUM_REGS-1:0] freeze_of(input logic [3:0] f);
    logic [`NUM_REGS-1:0] v;
    for (int r = 0; r < `NUM_REGS; r++) v[r] = |(DEP[r] & f);
    return v;
  endfunction : freeze_of

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // A bounded wait that ran out ends the run
  task automatic must(input logic c, input string what);
    check({31'h0, c}, 32'h1, what);
    if (c !== 1'b1) tally_and_finish();
  endtask : must

  // Edges of heartbeat and info symbol over 100 cycles (4 tick half period)
  task automatic count_flash;
    logic hb, is;
    tb_n = 0;
    ti_n = 0;
    repeat (100) begin
      hb = heartbeat_o;
      is = info_symbol_o;
      @(negedge clk_i);
      tb_n += (hb !== heartbeat_o);
      ti_n += (is !== info_symbol_o);
    end
  endtask : count_flash

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk_i);
    check(backlight_o, 1'b1, "lit in reset");
    check({loop_o, select_view_o, ok_indicator_o, freeze_o}, '0, "reset state");
    repeat (10) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (5) @(negedge clk_i);
    check(setup_avail_o, 1'b1, "setup open in transport");

    // Fault rows: dashes, frozen registers and fault code follow one cycle later
    foreach (rows[i]) begin
      sensor_fault_i = rows[i].fault;
      repeat (2) @(negedge clk_i);
      check(dash_o, rows[i].dash, "dashes");
      check(freeze_o, freeze_of(rows[i].fault), "frozen regs");
      check(info_fault_code_o, rows[i].fault, "fault code");
    end
    $display("test fault rows done");

    // Info symbol flashes on a code, heartbeat always
    sensor_fault_i = 4'h0;
    info_code_active_i = 1'b1;
    count_flash();
    check(ti_n >= 2, 1'b1, "info flashing");
    check(tb_n >= 2, 1'b1, "heartbeat");
    info_code_active_i = 1'b0;
    repeat (3) @(negedge clk_i);
    count_flash();
    check(ti_n, 0, "info quiet");
    check(tb_n >= 2, 1'b1, "heartbeat idle");
    $display("test flash done");

    // A bounce shorter than debounce does not wake the light
    key_operator_inst.press(1, 50, 300);
    check(backlight_o, 1'b0, "bounce ignored");
    key_operator_inst.press(1, SHORT, 0);
    check(backlight_o, 1'b1, "lit by key");
    check(view_index_o, 8'h01, "index stepped");
    repeat (100) @(negedge clk_i);
    check(backlight_o, 1'b1, "lit before timeout");
    repeat (100) @(negedge clk_i);
    check(backlight_o, 1'b0, "off after timeout");
    backlight_auto_i = 1'b0;
    repeat (200) @(negedge clk_i);
    check(backlight_o, 1'b1, "permanent light");
    $display("test backlight done");

    // Stored setting lights the indicator until a key press
    setting_stored_i = 1'b1;
    @(negedge clk_i);
    setting_stored_i = 1'b0;
    @(negedge clk_i);
    check(ok_indicator_o, 1'b1, "ok lit");
    key_operator_inst.press(2, SHORT, REST);
    check(ok_indicator_o, 1'b0, "ok cleared");

    // Country setting closes setup even in transport state
    country_setup_block_i = 1'b1;
    repeat (3) @(negedge clk_i);
    check(setup_avail_o, 1'b0, "country block");
    country_setup_block_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check(setup_avail_o, 1'b1, "country open");
    $display("test store and country done");

    // Short primary press leaves the view alone; long one opens selection
    key_operator_inst.press(0, SHORT, REST);
    check({select_view_o, loop_o}, 3'h0, "short primary");
    key_operator_inst.press(0, LONG, REST);
    check(select_view_o, 1'b1, "selection view");
    check(select_cand_o, 2'h0, "start at user");
    for (int k = 1; k <= 2; k++) begin
      key_operator_inst.press(1, SHORT, REST);
      check(select_cand_o, k[1:0], "step up");
    end
    key_operator_inst.press(0, SHORT, REST);
    check({select_view_o, loop_o, index_show_o}, {1'b0, 2'h2, 1'b1}, "setup entered");

    // Flow at one percent closes setup until seal break or reset and drops to user
    flow_ge_min_i = 1'b1;
    @(negedge clk_i);
    flow_ge_min_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check({setup_avail_o, loop_o, index_show_o}, 4'h0, "flow block");
    repeat (50) @(negedge clk_i);
    check(setup_avail_o, 1'b0, "block sticks");
    install_seal_broken_i = 1'b1;
    for (n = 0; n < 10 && setup_avail_o !== 1'b1; n++) @(negedge clk_i);
    must(setup_avail_o, "seal reopens setup");
    $display("test setup access done");

    // Test loop only with the verification seal broken
    verify_seal_broken_i = 1'b1;
    key_operator_inst.press(0, LONG, REST);
    for (int k = 1; k <= 3; k++) begin
      key_operator_inst.press(1, SHORT, REST);
      check(select_cand_o, k[1:0], "step to test");
    end
    key_operator_inst.press(0, SHORT, REST);
    check({loop_o, index_show_o}, {2'h3, 1'b1}, "test loop");
    verify_seal_broken_i = 1'b0;
    for (n = 0; n < 10 && loop_o !== 2'h0; n++) @(negedge clk_i);
    must(loop_o === 2'h0, "test loop lost");
    $display("test loop selection done");

    // Slow pulse flow reads zero after the idle count without pulses
    slow_pulse_mode_i = 1'b1;
    flow_pulse_i = 1'b1;
    repeat (5) @(negedge clk_i);
    flow_pulse_i = 1'b0;
    repeat (150) @(negedge clk_i);
    check(flow_zero_o, 1'b0, "flow still shown");
    for (n = 0; n < 100 && flow_zero_o !== 1'b1; n++) @(negedge clk_i);
    must(flow_zero_o, "flow forced zero");
    slow_pulse_mode_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check(flow_zero_o, 1'b0, "fast mode");
    $display("test flow idle done");

    // Reset in mid-run clears the flow block; leaving transport then closes setup
    install_seal_broken_i = 1'b0;
    resetn_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check({loop_o, setup_avail_o, backlight_o}, 4'h1, "mid-run reset");
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    check(setup_avail_o, 1'b1, "flow block volatile");
    transport_exit_i = 1'b1;
    @(negedge clk_i);
    transport_exit_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check(setup_avail_o, 1'b0, "transport left");
    $display("test reset and transport done");
    tally_and_finish();
  end

endmodule : meter_display_loop_control_tb
